// file: hdl/cpu_supervisor_watchdog.sv
// How it works
// - power fail forces both resets active
// - resets held 250 ms after power returns
// - margin select picks five or ten percent
// - manual reset active low, debounced internally
// - qualified press gives 250 ms reset minimum
// - press hold time counts from release
// - timeout select gives 150/600/1200 ms period
// - watchdog restarts full, idle during reset
// - kick falling edge restarts the period
// - expiry forces reset for 250 ms
// - actual timeout stays within maximum window
// - complementary outputs, low one open drain
// - watchdog cannot be disabled
// - stable low press resets within 20 ms
// - power fail resets within 175 us
module cpu_supervisor_watchdog #(
  parameter int unsigned HOLD_CYC     = supervisor_pkg::HOLD_CYC,
  parameter int unsigned DEBOUNCE_CYC = supervisor_pkg::DEBOUNCE_CYC,
  parameter int unsigned WD_SHORT_CYC = supervisor_pkg::WD_SHORT_CYC,
  parameter int unsigned WD_MID_CYC   = supervisor_pkg::WD_MID_CYC,
  parameter int unsigned WD_LONG_CYC  = supervisor_pkg::WD_LONG_CYC
) (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // supply monitor
  input  wire logic       power_fail_5pct_in,
  input  wire logic       power_fail_10pct_in,
  input  wire logic       supply_margin_select_in,
  // manual reset and watchdog controls
  input  wire logic       manual_reset_n_in,
  input  wire logic [1:0] timeout_select_in,
  input  wire logic       wdog_kick_n_in,
  // reset outputs
  output logic            cpu_reset_out,
  output logic            cpu_reset_n_o_out,
  output logic            cpu_reset_n_oe_out
);

  localparam int unsigned W = supervisor_pkg::CNT_W;

  supervisor_pkg::sup_state_t state_reg;

  logic          pressed;
  logic          kick_fall;
  logic          power_fail;
  logic          cause;
  logic          expired_reg;
  logic [W-1:0]  hold_cnt_reg;
  logic [W-1:0]  wd_cnt_reg;
  logic [W-1:0]  wd_limit_reg;
  logic          reset_req;
  logic [W-1:0]  active_cnt_reg;
  logic [W-1:0]  low_cnt_reg;

  // selected period as a cycle count
  function automatic logic [W-1:0] period_cyc(input logic [1:0] sel);
    case (sel)
      supervisor_pkg::TSEL_GND:   period_cyc = W'(WD_SHORT_CYC);
      supervisor_pkg::TSEL_FLOAT: period_cyc = W'(WD_MID_CYC);
      default:                    period_cyc = W'(WD_LONG_CYC);
    endcase
  endfunction : period_cyc

  manual_debounce #(
    .STABLE_CYC (DEBOUNCE_CYC)
  ) u_debounce (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .manual_reset_n_in (manual_reset_n_in),
    .pressed_out       (pressed)
  );

  kick_edge u_kick (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .wdog_kick_n_in (wdog_kick_n_in),
    .fall_out       (kick_fall)
  );

  // comparator outputs arrive per threshold; the select picks one
  assign power_fail = (supply_margin_select_in ==
                       supervisor_pkg::MARGIN_10PCT) ?
                      power_fail_10pct_in : power_fail_5pct_in;

  // pressed stays a cause until release, so hold counts from release
  assign cause = power_fail | pressed | expired_reg;

  // a fresh cause holds the counter too, so it never runs past its limit
  assign reset_req = (state_reg != supervisor_pkg::ST_RUN) | cause;

  // sequencer: a reset cause jumps to CAUSE from any state
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= supervisor_pkg::ST_HOLD;
    end
    else if (cause)
    begin
      state_reg <= supervisor_pkg::ST_CAUSE;
    end
    else
    begin
      case (state_reg)
        supervisor_pkg::ST_CAUSE: state_reg <= supervisor_pkg::ST_HOLD;
        supervisor_pkg::ST_HOLD:
        begin
          if (hold_cnt_reg == W'(HOLD_CYC - 1))
          begin
            state_reg <= supervisor_pkg::ST_RUN;
          end
        end
        supervisor_pkg::ST_RUN:   state_reg <= supervisor_pkg::ST_RUN;
        default:                  state_reg <= supervisor_pkg::ST_HOLD;
      endcase
    end
  end

  // hold counter restarts while any cause is active
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || cause || state_reg != supervisor_pkg::ST_HOLD)
    begin
      hold_cnt_reg <= '0;
    end
    else
    begin
      hold_cnt_reg <= hold_cnt_reg + W'(1);
    end
  end

  // watchdog: loaded while reset is active, no enable to turn it off
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wd_cnt_reg   <= '0;
      wd_limit_reg <= period_cyc(supervisor_pkg::TSEL_VCC);
    end
    else if (reset_req || kick_fall)
    begin
      wd_cnt_reg   <= '0;
      wd_limit_reg <= period_cyc(timeout_select_in);
    end
    else
    begin
      wd_cnt_reg <= wd_cnt_reg + W'(1);
    end
  end

  // expiry is a one-cycle cause; the hold phase then stretches it
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      expired_reg <= 1'b0;
    end
    else
    begin
      expired_reg <= state_reg == supervisor_pkg::ST_RUN && !kick_fall &&
                     wd_cnt_reg == wd_limit_reg - W'(1);
    end
  end

  // outputs: power-up state is reset active
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      cpu_reset_out      <= 1'b1;
      cpu_reset_n_o_out  <= 1'b0;
      cpu_reset_n_oe_out <= 1'b1;
    end
    else
    begin
      cpu_reset_out      <= reset_req;
      cpu_reset_n_o_out  <= 1'b0;
      cpu_reset_n_oe_out <= reset_req;
    end
  end

  // checker helpers only: how long the reset output has stood active and
  // how long the raw button has been low, both saturating at their limit
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !cpu_reset_out)
    begin
      active_cnt_reg <= '0;
    end
    else if (active_cnt_reg != W'(HOLD_CYC))
    begin
      active_cnt_reg <= active_cnt_reg + W'(1);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || manual_reset_n_in)
    begin
      low_cnt_reg <= '0;
    end
    else if (low_cnt_reg != W'(DEBOUNCE_CYC + 1))
    begin
      low_cnt_reg <= low_cnt_reg + W'(1);
    end
  end

  sequence pfail_s;
    power_fail ##1 1'b1;
  endsequence

  sequence kick_seen_s;
    $fell(wdog_kick_n_in) ##2 kick_fall;
  endsequence

  sequence release_s;
    pressed ##1 !pressed;
  endsequence

  pfail_reset_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      power_fail |=> cpu_reset_out)
    else $error("power fail did not assert reset");

  hold_min_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      $fell(cause) |-> (state_reg != supervisor_pkg::ST_RUN) [*8])
    else $error("reset released too soon after cause");

  hold_len_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      $fell(cpu_reset_out) |-> active_cnt_reg == W'(HOLD_CYC))
    else $error("reset active for less than the hold time");

  press_reset_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      pressed |=> cpu_reset_out && !cpu_reset_n_o_out)
    else $error("press did not reset");

  release_hold_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      release_s |-> (state_reg != supervisor_pkg::ST_RUN) [*8])
    else $error("reset released too soon after button release");

  hold_count_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      cause |=> hold_cnt_reg == '0)
    else $error("hold count not restarted by cause");

  wd_idle_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      state_reg != supervisor_pkg::ST_RUN |=> wd_cnt_reg == '0)
    else $error("watchdog ran during reset");

  wd_count_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      state_reg == supervisor_pkg::ST_RUN && !kick_fall && !cause |=>
        wd_cnt_reg == $past(wd_cnt_reg) + W'(1))
    else $error("watchdog stopped counting while running");

  kick_restart_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      kick_fall |=> wd_cnt_reg == '0)
    else $error("kick did not restart watchdog");

  kick_path_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      $fell(wdog_kick_n_in) |-> kick_seen_s ##1 wd_cnt_reg == '0)
    else $error("kick edge not carried through the synchroniser");

  expire_reset_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      expired_reg |=> cpu_reset_out ##1 cpu_reset_out)
    else $error("expiry did not assert reset");

  period_short_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      state_reg == supervisor_pkg::ST_HOLD &&
        timeout_select_in == supervisor_pkg::TSEL_GND |=>
        wd_limit_reg == W'(WD_SHORT_CYC))
    else $error("short period not loaded");

  period_mid_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      state_reg == supervisor_pkg::ST_HOLD &&
        timeout_select_in == supervisor_pkg::TSEL_FLOAT |=>
        wd_limit_reg == W'(WD_MID_CYC))
    else $error("middle period not loaded");

  period_long_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      state_reg == supervisor_pkg::ST_HOLD &&
        timeout_select_in == supervisor_pkg::TSEL_VCC |=>
        wd_limit_reg == W'(WD_LONG_CYC))
    else $error("long period not loaded");

  limit_max_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      wd_cnt_reg <= wd_limit_reg)
    else $error("watchdog overran its period");

  pfail_delay_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      pfail_s |-> ##[0:2] !cpu_reset_n_o_out && cpu_reset_n_oe_out)
    else $error("power fail reset too slow");

  press_limit_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      low_cnt_reg == W'(DEBOUNCE_CYC + 1) |-> cpu_reset_out)
    else $error("stable low button did not reset in time");

  margin_low_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      supply_margin_select_in == supervisor_pkg::MARGIN_5PCT &&
        power_fail_5pct_in |=> cpu_reset_out)
    else $error("five percent trip did not reset");

  margin_high_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      supply_margin_select_in == supervisor_pkg::MARGIN_10PCT &&
        power_fail_10pct_in |=> cpu_reset_out)
    else $error("ten percent trip did not reset");

  complement_a:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      cpu_reset_out == (cpu_reset_n_oe_out && !cpu_reset_n_o_out))
    else $error("reset outputs not complementary");

endmodule : cpu_supervisor_watchdog

// file: hdl/supervisor_pkg.sv
package supervisor_pkg;

  // clock and time bases
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1_000;

  // reset hold (least time, so round up)
  localparam int unsigned HOLD_MS     = 250;
  localparam int unsigned HOLD_CYC    = HOLD_MS * CYC_PER_MS;

  // manual reset debounce, must settle well inside the stable-low limit
  localparam int unsigned PRESS_LIMIT_MS = 20;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;

  // power-fail to reset assertion limit
  localparam int unsigned PFAIL_LIMIT_US  = 175;
  localparam int unsigned PFAIL_LIMIT_CYC = PFAIL_LIMIT_US * CYC_PER_US;

  // watchdog nominal periods (longest within max window, rounded down)
  localparam int unsigned WD_SHORT_MS  = 150;
  localparam int unsigned WD_MID_MS    = 600;
  localparam int unsigned WD_LONG_MS   = 1200;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CYC_PER_MS;
  localparam int unsigned WD_MID_CYC   = WD_MID_MS * CYC_PER_MS;
  localparam int unsigned WD_LONG_CYC  = WD_LONG_MS * CYC_PER_MS;

  // counter width covers the longest count (1.2 s = 120e6 cycles)
  localparam int unsigned CNT_W = 28;

  // timeout select encodings of the three-level pin
  localparam logic [1:0] TSEL_GND   = 2'h0;
  localparam logic [1:0] TSEL_FLOAT = 2'h1;
  localparam logic [1:0] TSEL_VCC   = 2'h2;

  // supply margin select: 0 = 5 percent, 1 = 10 percent
  localparam logic MARGIN_5PCT  = 1'b0;
  localparam logic MARGIN_10PCT = 1'b1;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_RUN,
    ST_CAUSE
  } sup_state_t;

endpackage : supervisor_pkg

// file: hdl/manual_debounce.sv
module manual_debounce #(
  parameter int unsigned STABLE_CYC = supervisor_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // raw button and qualified press
  input  wire logic manual_reset_n_in,
  output logic      pressed_out
);

  logic [27:0] stable_cnt_reg;
  logic        level_reg;

  // level only moves after the raw input has differed for the full window
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      stable_cnt_reg <= 28'h0000000;
      level_reg      <= 1'b1;
    end
    else if (manual_reset_n_in == level_reg)
    begin
      stable_cnt_reg <= 28'h0000000;
    end
    else if (stable_cnt_reg == 28'(STABLE_CYC - 1))
    begin
      stable_cnt_reg <= 28'h0000000;
      level_reg      <= manual_reset_n_in;
    end
    else
    begin
      stable_cnt_reg <= stable_cnt_reg + 28'h0000001;
    end
  end

  assign pressed_out = ~level_reg;

endmodule : manual_debounce

// file: hdl/kick_edge.sv
module kick_edge (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // kick strobe from the processor
  input  wire logic wdog_kick_n_in,
  output logic      fall_out
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two-stage synchroniser; only the second stage feeds the detector
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= wdog_kick_n_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign fall_out = last_reg & ~sync_reg;

endmodule : kick_edge

// file: tb/cpu_model.sv
module cpu_model #(
  parameter int unsigned GAP = 40
) (
  // clock and the reset line the processor sees
  input  wire logic core_clk_in,
  input  wire logic reset_line_n_in,
  // kick pattern control
  input  wire logic kick_en_in,
  input  wire logic stuck_low_in,
  // strobe to the supervisor
  output logic      wdog_kick_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned gap_reg;
  initial
  begin
    gap_reg = 0;
    wdog_kick_n_out = 1'b1;
  end
  // a processor held in reset runs no code, so only a stuck_low_in fault can drive the strobe low
  always @(posedge core_clk_in)
  begin
    if (stuck_low_in)
      wdog_kick_n_out <= 1'b0;
    else if (!reset_line_n_in || !kick_en_in)
    begin
      gap_reg <= 0;
      wdog_kick_n_out <= 1'b1;
    end
    else if (gap_reg >= GAP)
    begin
      gap_reg <= 0;
      wdog_kick_n_out <= 1'b0;
    end
    else
    begin
      gap_reg <= gap_reg + 1;
      if (gap_reg == 2)
        wdog_kick_n_out <= 1'b1;
    end
  end
endmodule : cpu_model

// file: tb/test_cpu_supervisor_watchdog.sv
module test_cpu_supervisor_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 50;
  localparam int DEB = 5;
  localparam int WD [4] = '{100, 200, 300, 300};
  logic       clk, rst, pf5, pf10, margin, mr_n, kick_en, stuck;
  logic [1:0] tsel;
  logic       kick_n, rst_hi, rst_n_o, rst_n_oe;
  wire logic  line_n;
  int         errors, samples_checked, n;
  // open-drain line with its pull-up
  assign line_n = rst_n_oe ? rst_n_o : 1'b1;
  cpu_supervisor_watchdog #(
    .HOLD_CYC(HOLD), .DEBOUNCE_CYC(DEB), .WD_SHORT_CYC(WD[0]),
    .WD_MID_CYC(WD[1]), .WD_LONG_CYC(WD[2])
  ) DUT (
    .core_clk_in(clk), .rst_in(rst), .power_fail_5pct_in(pf5),
    .power_fail_10pct_in(pf10), .supply_margin_select_in(margin),
    .manual_reset_n_in(mr_n), .timeout_select_in(tsel),
    .wdog_kick_n_in(kick_n), .cpu_reset_out(rst_hi),
    .cpu_reset_n_o_out(rst_n_o), .cpu_reset_n_oe_out(rst_n_oe)
  );
  cpu_model #(.GAP(40)) cpu (
    .core_clk_in(clk), .reset_line_n_in(line_n), .kick_en_in(kick_en),
    .stuck_low_in(stuck), .wdog_kick_n_out(kick_n)
  );
  task automatic tally_and_finish;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask : rng
  // n counts the edges until the reset output reaches lvl
  task automatic wait_lvl(input logic lvl, input int bound);
    for (n = 1; n <= bound; n++)
    begin
      @(posedge clk);
      #1;
      if (rst_hi === lvl)
      begin
        chk({31'h0, line_n}, {31'h0, ~lvl});
        return;
      end
    end
    errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, rst_hi, lvl);
    tally_and_finish();
  endtask : wait_lvl
  task automatic quiet(input int cyc);
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (rst_hi !== 1'b0)
        break;
    end
    chk({31'h0, rst_hi}, 32'h0);
  endtask : quiet
  task automatic power_fail;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk);
      margin <= s[0];
      pf5 <= s[0];
      pf10 <= ~s[0];
      quiet(10);
      @(posedge clk);
      pf5 <= 1'b1;
      pf10 <= 1'b1;
      wait_lvl(1'b1, 3);
      repeat (HOLD + 20) @(posedge clk);
      pf5 <= 1'b0;
      pf10 <= 1'b0;
      wait_lvl(1'b0, HOLD + 10);
      rng(n, HOLD, HOLD + 5);
    end
  endtask : power_fail
  task automatic manual_press;
    @(posedge clk);
    mr_n <= 1'b0;
    repeat (2) @(posedge clk);
    mr_n <= 1'b1;
    quiet(20);
    @(posedge clk);
    mr_n <= 1'b0;
    wait_lvl(1'b1, DEB + 6);
    rng(n, DEB, DEB + 6);
    repeat (HOLD + 20) @(posedge clk);
    #1;
    chk({31'h0, rst_hi}, 32'h1);
    @(posedge clk);
    mr_n <= 1'b1;
    wait_lvl(1'b0, HOLD + DEB + 10);
    rng(n, HOLD, HOLD + DEB + 6);
  endtask : manual_press
  task automatic kicking;
    quiet(5 * WD[0]);
    @(posedge clk);
    kick_en <= 1'b0;
    wait_lvl(1'b1, WD[0] + 10);
    @(posedge clk);
    stuck <= 1'b1;
    wait_lvl(1'b0, HOLD + 10);
    wait_lvl(1'b1, WD[0] + 10);
    rng(n, WD[0] - 2, WD[0] + 4);
    @(posedge clk);
    stuck <= 1'b0;
  endtask : kicking
  // every select code, the new one taken at the next release
  task automatic periods;
    for (int i = 0; i < 4; i++)
    begin
      wait_lvl(1'b0, HOLD + 10);
      rng(n, HOLD, HOLD + 5);
      wait_lvl(1'b1, WD[i] + 10);
      rng(n, WD[i] - 2, WD[i] + 4);
      @(posedge clk);
      tsel <= 2'(i + 1);
    end
  endtask : periods
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {rst, kick_en, mr_n} = 3'h7;
    {pf5, pf10, margin, stuck} = 4'h0;
    tsel = 2'h0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_lvl(1'b0, HOLD + 20);
    rng(n, HOLD, HOLD + 5);
    power_fail();
    manual_press();
    kicking();
    periods();
    tally_and_finish();
  end
endmodule : test_cpu_supervisor_watchdog
